// File: inc/ihr_pkg.sv
/*
  Shared types and constants of the host interrupt reporter.
  Assumes a single core clock domain; widths here size the struct carriers.
*/
package ihr_pkg;
  localparam int unsigned  IHR_SYS_W      = 16;
  localparam int unsigned  IHR_EV_W       = 16;
  localparam int unsigned  IHR_NQ         = 3;
  localparam int unsigned  IHR_DEPTH      = 8;
  localparam int unsigned  IHR_PIN_BIT    = 1;
  localparam logic [15:0]  IHR_CMD_RST    = 16'h0002;
  localparam logic [15:0]  IHR_BITS_RST   = 16'h0000;

  typedef enum logic [2:0] {
    IHR_SRC_NONE,
    IHR_SRC_SYS,
    IHR_SRC_Q1,
    IHR_SRC_Q2,
    IHR_SRC_Q3
  } ihr_src_e;

  // one report as the host sees it
  typedef struct packed {
    ihr_src_e              src;
    logic [IHR_SYS_W-1:0]  bits;
  } ihr_report_s;

  // one event pushed by firmware
  typedef struct packed {
    logic                  valid;
    logic [IHR_EV_W-1:0]   data;
  } ihr_event_s;
endpackage : ihr_pkg

// File: rtl/ihr_reporter.sv
/*
  Host interrupt reporter: sticky system sources with masks, three event
  queues, deferral of the two lowest queues, one registered active-low pin.
  Assumes all inputs come from core logic on core_clk; the host bus logic
  turns a host read of the indication register into a one-cycle pulse.
*/
// Functional notes
// - system and event interrupts share one pin
// - each system source has its own mask
// - many system sources reported together
// - event reports carry exactly one entry
// - three queues, each first in first out
// - pin asserts on unmasked system or queue
// - deferral holds queues two, three until release
// - pin low while pending, high otherwise
// - indication read clears the reported interrupt
// - no high pulse between back-to-back pending
// - system interrupts outrank every event queue
// - queue one, then two, then three
// - pin driven from a flip-flop
// - command word bit one shows pin
`timescale 1ns/100ps
module ihr_reporter
  import ihr_pkg::*;
#(
  parameter int unsigned DEPTH = ihr_pkg::IHR_DEPTH
)(
  input  wire logic                            core_clk,
  input  wire logic                            resetn,
  input  wire logic [ihr_pkg::IHR_SYS_W-1:0]   sys_set,
  input  wire logic [ihr_pkg::IHR_SYS_W-1:0]   sys_mask,
  input  wire logic                            defer_en,
  input  wire ihr_pkg::ihr_event_s             ev_push [ihr_pkg::IHR_NQ],
  input  wire logic                            ind_rd,
  output ihr_pkg::ihr_report_s                 ind_q,
  output logic [15:0]                          cmd_word_q,
  output logic [ihr_pkg::IHR_NQ-1:0]           ev_full_q,
  output logic                                 int_n_q
);
  import ihr_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  logic [IHR_SYS_W-1:0] sys_q;
  logic [IHR_SYS_W-1:0] sys_d;
  logic [IHR_SYS_W-1:0] sys_clr;
  logic [IHR_SYS_W-1:0] sys_hit;
  logic [IHR_SYS_W-1:0] sys_hit_d;
  logic                 rd_ok;
  logic                 rd_gap_q;
  logic [IHR_NQ-1:0]    pop;
  logic [IHR_NQ-1:0]    ne;
  logic [IHR_NQ-1:0]    ne_d;
  logic                 defer_open_q;
  logic                 defer_open_d;
  logic                 release_now;
  logic                 release_d;
  logic                 pend_d;
  logic [IHR_EV_W-1:0]  head [IHR_NQ];
  ihr_report_s          rep;

  // reads closer than two cycles apart would act on a stale report
  assign rd_ok = ind_rd && !rd_gap_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rd_gap_q <= 1'b0;
    else
      rd_gap_q <= ind_rd;
  end

  always_comb
  begin
    sys_clr = '0;
    pop     = '0;
    if (rd_ok)
    begin
      unique case (ind_q.src)
        IHR_SRC_SYS: sys_clr = ind_q.bits;
        IHR_SRC_Q1:  pop[0]  = 1'b1;
        IHR_SRC_Q2:  pop[1]  = 1'b1;
        IHR_SRC_Q3:  pop[2]  = 1'b1;
        IHR_SRC_NONE: ;
      endcase
    end
  end

  // sticky sources, set wins over clear
  assign sys_d = (sys_q & ~sys_clr) | sys_set;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      sys_q <= '0;
    else
      sys_q <= sys_d;
  end

  assign sys_hit   = sys_q & ~sys_mask;
  assign sys_hit_d = sys_d & ~sys_mask;

  for (genvar i = 0; i < IHR_NQ; i++)
  begin : g_q
    logic [IHR_EV_W-1:0] mem [DEPTH];
    logic [PW-1:0]       rp_q;
    logic [PW-1:0]       wp_q;
    logic [PW:0]         cnt_q;
    logic [PW:0]         cnt_d;
    logic                push;

    assign push  = ev_push[i].valid && (cnt_q != (PW+1)'(DEPTH));
    assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop[i]);
    assign ne[i]   = (cnt_q != '0);
    assign ne_d[i] = (cnt_d != '0);
    assign head[i] = mem[rp_q];

    always_ff @(posedge core_clk)
    begin
      if (push)
        mem[wp_q] <= ev_push[i].data;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        rp_q         <= '0;
        wp_q         <= '0;
        cnt_q        <= '0;
        ev_full_q[i] <= 1'b0;
      end
      else
      begin
        rp_q         <= rp_q + PW'(pop[i]);
        wp_q         <= wp_q + PW'(push);
        cnt_q        <= cnt_d;
        ev_full_q[i] <= (cnt_d == (PW+1)'(DEPTH));
      end
    end

    a_full_drops: assert property (@(posedge core_clk) disable iff (!resetn)
      (cnt_q == (PW+1)'(DEPTH)) |-> !push) else $error("push accepted into full queue");
    a_full_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      ev_full_q[i] == (cnt_q == (PW+1)'(DEPTH))) else $error("full flag disagrees with count");
  end

  // deferral window opens on system or queue one
  assign release_now  = !defer_en || defer_open_q || (|sys_hit) || ne[0];
  assign defer_open_d = (defer_open_q || (|sys_hit_d) || ne_d[0]) && (|ne_d || (|sys_hit_d));
  assign release_d    = !defer_en || defer_open_d;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      defer_open_q <= 1'b0;
    else
      defer_open_q <= defer_open_d;
  end

  always_comb
  begin
    rep.src  = IHR_SRC_NONE;
    rep.bits = '0;
    if (|sys_hit)
    begin
      rep.src  = IHR_SRC_SYS;
      rep.bits = sys_hit;
    end
    else if (ne[0])
    begin
      rep.src  = IHR_SRC_Q1;
      rep.bits = IHR_SYS_W'(head[0]);
    end
    else if (ne[1] && release_now)
    begin
      rep.src  = IHR_SRC_Q2;
      rep.bits = IHR_SYS_W'(head[1]);
    end
    else if (ne[2] && release_now)
    begin
      rep.src  = IHR_SRC_Q3;
      rep.bits = IHR_SYS_W'(head[2]);
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ind_q.src  <= IHR_SRC_NONE;
      ind_q.bits <= IHR_BITS_RST;
    end
    // held at a taken read, refreshed on the next edge
    else if (!rd_ok)
      ind_q <= rep;
  end

  assign pend_d = (|sys_hit_d) || ne_d[0] || (release_d && (ne_d[1] || ne_d[2]));

  // computed from next state, no gap
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      int_n_q <= 1'b1;
    else
      int_n_q <= !pend_d;
  end

  // pin level mirrored in command word
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cmd_word_q <= IHR_CMD_RST;
    else
    begin
      cmd_word_q              <= '0;
      cmd_word_q[IHR_PIN_BIT] <= !pend_d;
    end
  end

  // assertions
  sequence s_sys_pending;
    |(sys_q & ~sys_mask);
  endsequence

  sequence s_sys_next;
    |sys_hit_d;
  endsequence

  sequence s_pin_low_next;
    ##1 !int_n_q;
  endsequence

  a_sys_asserts_pin: assert property (@(posedge core_clk) disable iff (!resetn)
    s_sys_next |-> s_pin_low_next) else $error("system pending but pin high");
  a_queue_asserts: assert property (@(posedge core_clk) disable iff (!resetn)
    (!defer_en && ne_d != '0) |=> !int_n_q) else $error("queue pending but pin high");
  a_idle_pin_high: assert property (@(posedge core_clk) disable iff (!resetn)
    (!pend_d) |=> int_n_q) else $error("pin low with nothing pending");
  a_cmd_tracks_pin: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_word_q[IHR_PIN_BIT] == int_n_q && cmd_word_q[0] == 1'b0) else $error("command word pin bit wrong");
  a_sys_first: assert property (@(posedge core_clk) disable iff (!resetn)
    (s_sys_pending and !rd_ok) |=> ind_q.src == IHR_SRC_SYS) else $error("system not reported first");
  a_q1_first: assert property (@(posedge core_clk) disable iff (!resetn)
    (!(|sys_hit) && ne[0] && !rd_ok) |=> ind_q.src == IHR_SRC_Q1) else $error("queue one not first");
  a_q2_over_q3: assert property (@(posedge core_clk) disable iff (!resetn)
    (!(|sys_hit) && !ne[0] && ne[1] && release_now && !rd_ok) |=> ind_q.src == IHR_SRC_Q2)
    else $error("queue two not before queue three");
  a_q3_last: assert property (@(posedge core_clk) disable iff (!resetn)
    (!(|sys_hit) && !ne[0] && !ne[1] && ne[2] && release_now && !rd_ok) |=> ind_q.src == IHR_SRC_Q3)
    else $error("queue three not reported");
  a_one_source: assert property (@(posedge core_clk) disable iff (!resetn)
    $onehot0({|sys_clr, pop})) else $error("read cleared more than one source");
  a_defer_holds: assert property (@(posedge core_clk) disable iff (!resetn)
    (defer_en && !defer_open_d && !(|sys_hit_d) && !ne_d[0]) |=> int_n_q) else $error("deferred queue asserted pin");
  a_q1_releases: assert property (@(posedge core_clk) disable iff (!resetn)
    (defer_en && ne_d[0] && (ne_d[1] || ne_d[2])) |=> (defer_open_q && !int_n_q))
    else $error("queue one did not release deferral");
  // read of system report clears bits
  a_read_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    (rd_ok && ind_q.src == IHR_SRC_SYS) |=> ((sys_q & $past(ind_q.bits) & ~$past(sys_set)) == '0))
    else $error("system bits not cleared by read");
  // read pops only a filled queue
  a_pop_nonempty: assert property (@(posedge core_clk) disable iff (!resetn)
    (pop & ~ne) == '0) else $error("read popped an empty queue");
  // pin stays low across a read if still pending
  a_no_glitch: assert property (@(posedge core_clk) disable iff (!resetn)
    (!int_n_q && rd_ok && pend_d) |=> !int_n_q) else $error("pin pulsed high while pending");
  a_mask_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    ((sys_d & ~sys_mask) == '0 && ne_d == '0) |=> int_n_q) else $error("masked source asserted pin");
  a_mask_no_open: assert property (@(posedge core_clk) disable iff (!resetn)
    (defer_en && !defer_open_q && !ne_d[0] && sys_hit_d == '0) |=> !defer_open_q)
    else $error("masked source opened deferral");
endmodule : ihr_reporter

// File: verification/ihr_host_model.sv
/*
  Host side model: reads the indication register while the pin is low.
  Assumes the reporter on core_clk; gap plus one is the idle count between reads.
*/
`timescale 1ns/100ps
module ihr_host_model
  import ihr_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 go,
  input  wire logic [3:0]           gap,
  input  wire logic                 int_n_q,
  input  wire ihr_pkg::ihr_report_s ind_q,
  output logic                      ind_rd,
  output logic                      rep_v,
  output ihr_pkg::ihr_report_s      rep
);
  logic [3:0] wait_q;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ind_rd <= 1'b0;
      rep_v  <= 1'b0;
      rep    <= '0;
      wait_q <= 4'h0;
    end
    else if (ind_rd)
    begin
      ind_rd <= 1'b0;
      rep_v  <= 1'b1;
      rep    <= ind_q;
      wait_q <= 4'h0;
    end
    else
    begin
      rep_v  <= 1'b0;
      wait_q <= (go && !int_n_q && wait_q < gap) ? wait_q + 4'h1 : (go && !int_n_q ? wait_q : 4'h0);
      ind_rd <= go && !int_n_q && wait_q >= gap;
    end
  end
endmodule : ihr_host_model

// File: verification/host_interrupt_reporter_bench.sv
/*
  Self-checking bench: loads sources with the host held off, then lets the
  host model drain reports. Assumes DEPTH of 2 so a queue fills quickly.
*/
`timescale 1ns/100ps
module host_interrupt_reporter_bench;
  import ihr_pkg::*;
  localparam int unsigned DEPTH = 2;
  logic        core_clk, resetn, defer_en, ind_rd, go, int_n_q, rep_v;
  logic [15:0] sys_set, sys_mask, cmd_word_q, d [5];
  logic [2:0]  ev_full_q;
  logic [3:0]  gap;
  ihr_event_s  ev_push [IHR_NQ];
  ihr_report_s ind_q, rep, exp_q [$];
  int          mismatches, tests_run, cycles, seed;

  ihr_reporter #(.DEPTH(DEPTH)) uut (.core_clk, .resetn, .sys_set, .sys_mask, .defer_en, .ev_push,
    .ind_rd, .ind_q, .cmd_word_q, .ev_full_q, .int_n_q);
  ihr_host_model host (.core_clk, .resetn, .go, .gap, .int_n_q, .ind_q, .ind_rd, .rep_v, .rep);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic note(input ihr_src_e s, input logic [15:0] b);
    exp_q.push_back('{s, b});
  endtask : note

  task automatic push(input int q, input logic [15:0] v);
    @(posedge core_clk);
    ev_push[q] <= '{1'b1, v};
    @(posedge core_clk);
    ev_push[q] <= '{1'b0, 16'h0000};
  endtask : push

  task automatic sys(input logic [15:0] b);
    @(posedge core_clk);
    sys_set <= b;
    @(posedge core_clk);
    sys_set <= 16'h0000;
  endtask : sys

  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() != 0; i++)
      @(posedge core_clk);
    repeat (6) @(posedge core_clk);
    check(exp_q.size(), 0);
    check(int_n_q, 1'b1);
  endtask : drain

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
    if (rep_v === 1'b1)
      check(rep, exp_q.size() != 0 ? exp_q.pop_front() : 19'h7FFFF);
  end

  initial
  begin
    {resetn, defer_en, go, sys_set, sys_mask} = '0;
    foreach (ev_push[i]) ev_push[i] = '{1'b0, 16'h0000};
    gap = 4'h2;
    seed = 19007;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    check(int_n_q, 1'b1);
    check(cmd_word_q, IHR_CMD_RST);
    check(cmd_word_q[7:0], 8'h02);
    @(posedge core_clk);
    check(cmd_word_q[15:8], 8'h00);
    $display("test reset done");
    sys_mask <= 16'h0008;
    sys(16'h0008);
    repeat (4) @(posedge core_clk);
    check(int_n_q, 1'b1);
    note(IHR_SRC_SYS, 16'h0009);
    sys_mask <= 16'h0000;
    sys(16'h0001);
    repeat (3) @(posedge core_clk);
    check(cmd_word_q, 16'h0000);
    go <= 1'b1;
    drain();
    $display("test mask done");
    for (int r = 0; r < 3; r++)
    begin
      go <= 1'b0;
      foreach (d[i]) d[i] = 16'($random(seed));
      d[4] = d[4] | 16'h0001;
      note(IHR_SRC_SYS, d[4]);
      note(IHR_SRC_Q1, d[0]);
      note(IHR_SRC_Q1, d[1]);
      note(IHR_SRC_Q2, d[2]);
      note(IHR_SRC_Q3, d[3]);
      push(2, d[3]);
      push(1, d[2]);
      push(0, d[0]);
      push(0, d[1]);
      push(0, d[2]);
      check(ev_full_q, 3'b001);
      sys(d[4]);
      gap <= 4'(2 + ($unsigned($random(seed)) % 6));
      go <= 1'b1;
      drain();
    end
    $display("test priority done");
    defer_en <= 1'b1;
    push(1, d[0]);
    push(2, d[1]);
    repeat (8) @(posedge core_clk);
    check(int_n_q, 1'b1);
    sys_mask <= 16'h0002;
    sys(16'h0002);
    repeat (4) @(posedge core_clk);
    check(int_n_q, 1'b1);
    note(IHR_SRC_Q1, d[2]);
    note(IHR_SRC_Q2, d[0]);
    note(IHR_SRC_Q3, d[1]);
    push(0, d[2]);
    drain();
    note(IHR_SRC_SYS, 16'h0002);
    defer_en <= 1'b0;
    sys_mask <= 16'h0000;
    drain();
    $display("test defer done");
    tally_and_finish();
  end
endmodule : host_interrupt_reporter_bench
